// [common/pefs_pkg.sv]
// Package: constants, types and register map for the port E function select block
package pefs_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [11:0] HIGH_SEL_OFS  = 12'h000;
  localparam logic [11:0] LOW_SEL_OFS   = 12'h004;
  localparam logic [11:0] DIR_OFS       = 12'h008;
  localparam logic [15:0] SEL_RESET     = 16'h0000;
  localparam logic [15:0] HIGH_WR_MASK  = 16'hFD55;
  localparam logic [15:0] LOW_WR_MASK   = 16'h5400;
  localparam logic [15:0] DIR_WR_MASK   = 16'hFFFF;

  // Field positions in the high register
  localparam int P15_POS = 14;
  localparam int P14_POS = 12;
  localparam int P13_POS = 10;
  localparam int P12_POS = 8;
  localparam int P11_POS = 6;
  localparam int P10_POS = 4;
  localparam int P9_POS  = 2;
  localparam int P8_POS  = 0;
  // Field positions in the low register
  localparam int P7_POS  = 14;
  localparam int P6_POS  = 12;
  localparam int P5_POS  = 10;

  // ****************************************************************
  // Types
  // ****************************************************************
  // Pin function, one code per pin
  typedef enum logic [2:0] {
    PEFS_GPIO     = 3'h0,
    PEFS_TIMER    = 3'h1,
    PEFS_DMA_ACK  = 3'h2,
    PEFS_IRQ_OUT  = 3'h3,
    PEFS_AH_OUT   = 3'h4,
    PEFS_MANUAL_RESET_IN_IN  = 3'h5,
    PEFS_RESERVED = 3'h6
  } pefs_func_t;

  typedef struct packed {
    logic [15:0] high_sel;
    logic [15:0] low_sel;
    logic [15:0] dir;
  } pefs_regs_t;

  typedef struct packed {
    logic [15:0] gpio_sel;    // Pin owned by port logic
    logic [15:0] timer_sel;   // Pin owned by timer
    logic [15:0] drive_en;    // Pin drives when set
    logic        dma_ack1_sel;
    logic        dma_ack0_sel;
    logic        irq_out_sel;
    logic        ah_sel;
    logic        manual_reset_in_sel;
    logic [15:0] reserved_sel;
  } pefs_route_t;

endpackage : pefs_pkg

// [hdl/pefs_decode.sv]
// Pin function decoder with single-chip overrides
`timescale 1ns/1ps
module pefs_decode (
  // Register contents
  input  wire logic [15:0]                high_sel,
  input  wire logic [15:0]                low_sel,
  // Operating mode
  input  wire logic                       single_chip,
  // Decoded functions
  output pefs_pkg::pefs_func_t            func [16]
);

  // Pin 13 in entry 0, pin 15 in entry 2
  pefs_pkg::pefs_func_t two_bit_func [3];
  // Pin 5 in bit 0, pin 12 in bit 7
  logic [7:0]           one_bit_sel;

  // Two-bit fields, mode overrides applied without a register stage
  always_comb begin
    unique case (high_sel[pefs_pkg::P15_POS +: 2])
      2'h0: two_bit_func[2] = pefs_pkg::PEFS_GPIO;
      2'h1: two_bit_func[2] = pefs_pkg::PEFS_TIMER;
      2'h2: two_bit_func[2] = single_chip ? pefs_pkg::PEFS_GPIO : pefs_pkg::PEFS_DMA_ACK;
      2'h3: two_bit_func[2] = single_chip ? pefs_pkg::PEFS_RESERVED : pefs_pkg::PEFS_IRQ_OUT;
    endcase
    unique case (high_sel[pefs_pkg::P14_POS +: 2])
      2'h0: two_bit_func[1] = pefs_pkg::PEFS_GPIO;
      2'h1: two_bit_func[1] = pefs_pkg::PEFS_TIMER;
      2'h2: two_bit_func[1] = single_chip ? pefs_pkg::PEFS_GPIO : pefs_pkg::PEFS_DMA_ACK;
      2'h3: two_bit_func[1] = single_chip ? pefs_pkg::PEFS_GPIO : pefs_pkg::PEFS_AH_OUT;
    endcase
    unique case (high_sel[pefs_pkg::P13_POS +: 2])
      2'h0: two_bit_func[0] = pefs_pkg::PEFS_GPIO;
      2'h1: two_bit_func[0] = pefs_pkg::PEFS_TIMER;
      2'h2: two_bit_func[0] = pefs_pkg::PEFS_MANUAL_RESET_IN_IN;
      2'h3: two_bit_func[0] = pefs_pkg::PEFS_RESERVED;
    endcase
  end

  // Single-bit fields gathered in pin order so one loop serves them all
  assign one_bit_sel = {high_sel[pefs_pkg::P12_POS], high_sel[pefs_pkg::P11_POS],
                        high_sel[pefs_pkg::P10_POS], high_sel[pefs_pkg::P9_POS],
                        high_sel[pefs_pkg::P8_POS],  low_sel[pefs_pkg::P7_POS],
                        low_sel[pefs_pkg::P6_POS],   low_sel[pefs_pkg::P5_POS]};

  // One driver per pin; a single process type keeps each array entry single-sourced
  genvar i;
  generate
    for (i = 0; i < 16; i++) begin : g_pin
      if (i >= 13) begin : g_two
        assign func[i] = two_bit_func[i - 13];
      end else if (i >= 5) begin : g_one
        assign func[i] = one_bit_sel[i - 5] ? pefs_pkg::PEFS_TIMER : pefs_pkg::PEFS_GPIO;
      end else begin : g_port
        // Pins 4..0 encodings are not covered; they stay port pins
        assign func[i] = pefs_pkg::PEFS_GPIO;
      end
    end
  endgenerate

endmodule : pefs_decode

// [hdl/pefs_route.sv]
// Per-pin routing vectors and direction control
`timescale 1ns/1ps
module pefs_route (
  // Decoded functions and direction
  input  pefs_pkg::pefs_func_t            func [16],
  input  wire logic [15:0]                dir,
  // Routing
  output pefs_pkg::pefs_route_t           route
);

  // One entry per pin
  genvar i;
  generate
    for (i = 0; i < 16; i++) begin : g_pin
      assign route.gpio_sel[i]     = (func[i] == pefs_pkg::PEFS_GPIO);
      assign route.timer_sel[i]    = (func[i] == pefs_pkg::PEFS_TIMER);
      assign route.reserved_sel[i] = (func[i] == pefs_pkg::PEFS_RESERVED);
      // Direction bit only counts for port or timer ownership
      assign route.drive_en[i] = ((func[i] == pefs_pkg::PEFS_GPIO) || (func[i] == pefs_pkg::PEFS_TIMER))
                                 ? dir[i]
                                 : ((func[i] == pefs_pkg::PEFS_DMA_ACK) || (func[i] == pefs_pkg::PEFS_IRQ_OUT)
                                    || (func[i] == pefs_pkg::PEFS_AH_OUT));
    end
  endgenerate

  // Peripheral-specific selects
  assign route.dma_ack1_sel = (func[15] == pefs_pkg::PEFS_DMA_ACK);
  assign route.irq_out_sel  = (func[15] == pefs_pkg::PEFS_IRQ_OUT);
  assign route.dma_ack0_sel = (func[14] == pefs_pkg::PEFS_DMA_ACK);
  assign route.ah_sel       = (func[14] == pefs_pkg::PEFS_AH_OUT);
  assign route.manual_reset_in_sel     = (func[13] == pefs_pkg::PEFS_MANUAL_RESET_IN_IN);

endmodule : pefs_route

// [hdl/pefs_top.sv]
// Port E function select: APB registers, decoder and routing
`timescale 1ns/1ps
module pefs_top (
  // Clock and power-on reset
  input  wire logic                 clk,
  input  wire logic                 rstn,
  // APB slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  input  wire logic [3:0]           pstrb,
  output logic                      pready,
  output logic      [31:0]          prdata,
  output logic                      pslverr,
  // Operating mode from the chip
  input  wire logic                 single_chip,
  // Pin routing
  output pefs_pkg::pefs_route_t     route
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    pefs_pkg::pefs_regs_t regs;
    logic [31:0]          rdata;
    logic                 err;
  } pefs_state_t;

  pefs_state_t          st_r;
  pefs_state_t          st_nxt;
  pefs_pkg::pefs_func_t func [16];
  logic                 access;
  logic                 hit_high;
  logic                 hit_low;
  logic                 hit_dir;
  logic [15:0]          wmask;

  // Single-cycle access phase, no wait states
  assign access   = psel && penable;
  assign hit_high = (paddr == pefs_pkg::HIGH_SEL_OFS);
  assign hit_low  = (paddr == pefs_pkg::LOW_SEL_OFS);
  assign hit_dir  = (paddr == pefs_pkg::DIR_OFS);
  assign pready   = 1'b1;
  assign wmask    = {{8{pstrb[1]}}, {8{pstrb[0]}}};

  // Next state: masked writes drop reserved bits
  always_comb begin
    st_nxt = st_r;
    if (psel && !penable) begin
      st_nxt.err   = !(hit_high || hit_low || hit_dir);
      st_nxt.rdata = 32'h0000_0000;
      if (!pwrite) begin
        if (hit_high) st_nxt.rdata = {16'h0000, st_r.regs.high_sel};
        if (hit_low)  st_nxt.rdata = {16'h0000, st_r.regs.low_sel};
        if (hit_dir)  st_nxt.rdata = {16'h0000, st_r.regs.dir};
      end
    end
    if (access && pwrite) begin
      if (hit_high) begin
        st_nxt.regs.high_sel = (st_r.regs.high_sel & ~(wmask & pefs_pkg::HIGH_WR_MASK))
                             | (pwdata[15:0] & wmask & pefs_pkg::HIGH_WR_MASK);
      end
      if (hit_low) begin
        st_nxt.regs.low_sel = (st_r.regs.low_sel & ~(wmask & pefs_pkg::LOW_WR_MASK))
                            | (pwdata[15:0] & wmask & pefs_pkg::LOW_WR_MASK);
      end
      if (hit_dir) begin
        st_nxt.regs.dir = (st_r.regs.dir & ~wmask) | (pwdata[15:0] & wmask);
      end
    end
  end

  // Only the power-on reset reaches these flops; other resets never arrive here
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata  = st_r.rdata;
  assign pslverr = access && st_r.err;

  // ****************************************************************
  // Decode and route
  // ****************************************************************
  pefs_decode u_decode (
    .high_sel    (st_r.regs.high_sel),
    .low_sel     (st_r.regs.low_sel),
    .single_chip (single_chip),
    .func        (func)
  );

  pefs_route u_route (
    .func  (func),
    .dir   (st_r.regs.dir),
    .route (route)
  );

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_pin15_sc;
    @(posedge clk) disable iff (!rstn)
      (single_chip && st_r.regs.high_sel[15:14] == 2'h2) |-> route.gpio_sel[15];
  endproperty
  a_pin15_sc: assert property (p_pin15_sc) else $error("pin15 not gpio in single chip");

  property p_pin15_irq;
    @(posedge clk) disable iff (!rstn)
      (!single_chip && st_r.regs.high_sel[15:14] == 2'h3) |-> route.irq_out_sel && route.drive_en[15];
  endproperty
  a_pin15_irq: assert property (p_pin15_irq) else $error("pin15 irq route wrong");

  property p_pin14_sc;
    @(posedge clk) disable iff (!rstn)
      single_chip |-> !route.ah_sel && !route.dma_ack0_sel;
  endproperty
  a_pin14_sc: assert property (p_pin14_sc) else $error("pin14 peripheral in single chip");

  property p_pin14_dack;
    @(posedge clk) disable iff (!rstn)
      (!single_chip && st_r.regs.high_sel[13:12] == 2'h2) |-> route.dma_ack0_sel && route.drive_en[14];
  endproperty
  a_pin14_dack: assert property (p_pin14_dack) else $error("pin14 dma ack route wrong");

  property p_pin15_dack;
    @(posedge clk) disable iff (!rstn)
      (!single_chip && st_r.regs.high_sel[15:14] == 2'h2) |-> route.dma_ack1_sel && route.drive_en[15];
  endproperty
  a_pin15_dack: assert property (p_pin15_dack) else $error("pin15 dma ack route wrong");

  property p_pin13_manual_reset_in;
    @(posedge clk) disable iff (!rstn)
      route.manual_reset_in_sel |-> (st_r.regs.high_sel[11:10] == 2'h2) && !route.drive_en[13];
  endproperty
  a_pin13_manual_reset_in: assert property (p_pin13_manual_reset_in) else $error("pin13 manual_reset_in route wrong");

  property p_rsvd_high;
    @(posedge clk) disable iff (!rstn)
      (st_r.regs.high_sel & ~pefs_pkg::HIGH_WR_MASK) == 16'h0000;
  endproperty
  a_rsvd_high: assert property (p_rsvd_high) else $error("high reserved bit set");

  property p_rsvd_low;
    @(posedge clk) disable iff (!rstn)
      (st_r.regs.low_sel & ~pefs_pkg::LOW_WR_MASK) == 16'h0000;
  endproperty
  a_rsvd_low: assert property (p_rsvd_low) else $error("low reserved bit set");

  property p_timer_bits;
    @(posedge clk) disable iff (!rstn)
      route.timer_sel[12:5] == {st_r.regs.high_sel[8], st_r.regs.high_sel[6], st_r.regs.high_sel[4],
                                st_r.regs.high_sel[2], st_r.regs.high_sel[0], st_r.regs.low_sel[14],
                                st_r.regs.low_sel[12], st_r.regs.low_sel[10]};
  endproperty
  a_timer_bits: assert property (p_timer_bits) else $error("timer select mismatch");

  property p_dir;
    @(posedge clk) disable iff (!rstn)
      (route.gpio_sel[9] || route.timer_sel[9]) |-> route.drive_en[9] == st_r.regs.dir[9];
  endproperty
  a_dir: assert property (p_dir) else $error("direction not applied");

  property p_write_next;
    @(posedge clk) disable iff (!rstn)
      (access && pwrite && hit_low && pstrb[1]) |=> st_r.regs.low_sel[14] == $past(pwdata[14]);
  endproperty
  a_write_next: assert property (p_write_next) else $error("write not taken");

  property p_reset_gpio;
    @(posedge clk) $rose(rstn) |-> route.gpio_sel == 16'hFFFF;
  endproperty
  a_reset_gpio: assert property (p_reset_gpio) else $error("pins not gpio after reset");

  c_irq:  cover property (@(posedge clk) disable iff (!rstn) route.irq_out_sel);
  c_ah:   cover property (@(posedge clk) disable iff (!rstn) route.ah_sel);
  c_manual_reset_in: cover property (@(posedge clk) disable iff (!rstn) route.manual_reset_in_sel);
  c_rsvd: cover property (@(posedge clk) disable iff (!rstn) route.reserved_sel[15]);
  c_dack: cover property (@(posedge clk) disable iff (!rstn) route.dma_ack1_sel);

endmodule : pefs_top

// [testbench/pefs_pin_model.sv]
// Far-side pin model: resolves each port E pin from the routing the block gives it
`timescale 1ns/1ps
module pefs_pin_model (
  // Routing from the block
  input  wire pefs_pkg::pefs_route_t route,
  // Output values of port logic and timer
  input  wire logic [15:0]           gpio_out,
  input  wire logic [15:0]           timer_out,
  // Resolved pin levels
  output logic      [15:0]           pin
);
  // An undriven pin floats to the board pull-up, never to its last value
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      pin[i] = route.drive_en[i] ? (route.timer_sel[i] ? timer_out[i] : gpio_out[i]) : 1'b1;
    end
  end
endmodule : pefs_pin_model

// [testbench/tb_top.sv]
// Self-checking bench for the port E function select block
`timescale 1ns/1ps
module tb_top;
  logic clk, rstn, psel, penable, pwrite, pready, pslverr, single_chip, go;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [15:0] gout, tout, pin, sh, sl, sd;
  pefs_pkg::pefs_route_t route, ge, gr;
  logic [33:0] bq [$];
  pefs_pkg::pefs_route_t rq [$];
  int err_total, compares;

  pefs_top i_pefs_top (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .single_chip(single_chip), .route(route));
  pefs_pin_model i_pefs_pin_model (.route(route), .gpio_out(gout), .timer_out(tout), .pin(pin));

  // 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Expected routing, worked out from the field encodings and the mode overrides
  function automatic pefs_pkg::pefs_route_t exp_route(input logic [15:0] h, l, d, input logic sc);
    pefs_pkg::pefs_route_t e;
    e = '0;
    e.timer_sel = {h[15:14] == 2'h1, h[13:12] == 2'h1, h[11:10] == 2'h1, h[8], h[6], h[4], h[2], h[0],
                   l[14], l[12], l[10], 5'h00};
    e.dma_ack1_sel = h[15:14] == 2'h2 && !sc;
    e.irq_out_sel  = h[15:14] == 2'h3 && !sc;
    e.dma_ack0_sel = h[13:12] == 2'h2 && !sc;
    e.ah_sel       = h[13:12] == 2'h3 && !sc;
    e.manual_reset_in_sel     = h[11:10] == 2'h2;
    e.reserved_sel[15] = h[15:14] == 2'h3 && sc;
    e.reserved_sel[13] = h[11:10] == 2'h3;
    e.gpio_sel = ~e.timer_sel & ~{e.dma_ack1_sel | e.irq_out_sel | e.reserved_sel[15],
                 e.dma_ack0_sel | e.ah_sel, e.manual_reset_in_sel | e.reserved_sel[13], 13'h0000};
    // Peripheral outputs drive regardless of the direction bit
    e.drive_en = (d & (e.gpio_sel | e.timer_sel))
               | {e.dma_ack1_sel | e.irq_out_sel, e.dma_ack0_sel | e.ah_sel, 14'h0000};
    return e;
  endfunction : exp_route

  task automatic cmp_val(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp_val

  task automatic cmp_route(input pefs_pkg::pefs_route_t e, input pefs_pkg::pefs_route_t g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("mismatch route expected %h seen %h", e, g);
    end
  endtask : cmp_route

  // One APB transfer; the expected answer is queued for the monitor
  task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d, input logic [15:0] x,
                     input logic e);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {16'($urandom), d};
    bq.push_back({w | e, e, 16'h0000, x});
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Shadow copies keep only the writable bits
  task automatic setregs(input logic [15:0] h, input logic [15:0] l, input logic [15:0] d);
    apb(1'b1, pefs_pkg::HIGH_SEL_OFS, h, 16'h0000, 1'b0);
    apb(1'b1, pefs_pkg::LOW_SEL_OFS, l, 16'h0000, 1'b0);
    apb(1'b1, pefs_pkg::DIR_OFS, d, 16'h0000, 1'b0);
    sh = h & pefs_pkg::HIGH_WR_MASK;
    sl = l & pefs_pkg::LOW_WR_MASK;
    sd = d;
  endtask : setregs

  task automatic verify();
    apb(1'b0, pefs_pkg::HIGH_SEL_OFS, 16'h0000, sh, 1'b0);
    apb(1'b0, pefs_pkg::LOW_SEL_OFS, 16'h0000, sl, 1'b0);
    apb(1'b0, pefs_pkg::DIR_OFS, 16'h0000, sd, 1'b0);
    rq.push_back(exp_route(sh, sl, sd, single_chip));
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
  endtask : verify

  // Monitor: takes the oldest note whenever a result appears
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1) begin
      cmp_val("pslverr", {31'h00000000, bq[0][32]}, {31'h00000000, pslverr});
      if (!bq[0][33]) cmp_val("prdata", bq[0][31:0], prdata);
      void'(bq.pop_front());
    end
    if (go) begin
      ge = rq.pop_front();
      gr = route;
      cmp_route(ge, gr);
      cmp_val("pin", {16'h0000, ((ge.drive_en & ((ge.timer_sel & tout) | (ge.gpio_sel & gout))) | ~ge.drive_en)
              & (ge.gpio_sel | ge.timer_sel)}, {16'h0000, pin & (ge.gpio_sel | ge.timer_sel)});
    end
  end

  task automatic print_verdict();
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict

  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    print_verdict();
  end

  initial begin
    {rstn, psel, penable, pwrite, single_chip, go} = '0;
    {paddr, pwdata, gout, tout, sh, sl, sd} = '0;
    err_total = 0;
    compares = 0;
    void'($urandom(32'hCA7FAE78));
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    verify();
    $display("test reset_values done");
    setregs(16'hFFFF, 16'hFFFF, 16'hFFFF);
    verify();
    single_chip <= 1'b1;
    verify();
    $display("test all_ones done");
    // Every code of the two-bit fields in both operating modes
    for (int m = 0; m < 2; m++) begin
      for (int c = 0; c < 4; c++) begin
        single_chip <= m[0];
        setregs({c[1:0], c[1:0], c[1:0], 10'($urandom)}, 16'($urandom), 16'($urandom));
        verify();
      end
    end
    $display("test field_codes done");
    repeat (12) begin
      gout <= 16'($urandom);
      tout <= 16'($urandom);
      setregs(16'($urandom), 16'($urandom), 16'($urandom));
      single_chip <= 1'($urandom);
      verify();
    end
    $display("test random done");
    // Unmapped place: error answer and no change to any register
    apb(1'b1, 12'h00C, 16'hFFFF, 16'h0000, 1'b1);
    apb(1'b0, 12'h00C, 16'h0000, 16'h0000, 1'b1);
    verify();
    $display("test unmapped done");
    setregs(16'hFD55, 16'h5400, 16'hA5A5);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    {sh, sl, sd} = '0;
    verify();
    $display("test mid_reset done");
    print_verdict();
  end
endmodule : tb_top
